// File: src/tcs_sequencer.sv
// Telemetry calibration sequencer: selector, voltage stepper, sideband relay and AXI4-Lite slave.
//
// Functional notes
// R1 - Inflight start from either relay enables drivers and sets control flip-flop.
// R2 - Control set moves selector to step one and opens advance and clock gates.
// R3 - Step one issues calibrate command one through the enabled driver.
// R4 - Each completed stepper pass advances the selector to the next command.
// R5 - Commander holds start at least 4.2 seconds to keep drivers enabled.
// R6 - Selector stays inactive in preflight mode.
// R7 - Preflight relay selects preflight; either start relay selects inflight.
// R8 - Stepper output is only one of five levels, zero to full scale.
// R9 - Preflight mismatch opens gates and restarts stepper at first step.
// R10 - Open clock gate yields a step every 140 ms advancing the level.
// R11 - Stepping continues while output differs from command; cycle command never matches.
// R12 - One full five-level pass lasts 700 ms.
// R13 - Inflight forces permanent mismatch, ground levels ignored.
// R14 - Inflight run steps continuously until six consecutive passes complete.
// R15 - Sideband relay closes whenever a sideband telemeter is selected.
// R16 - Ground may select all sideband telemeters via ground relay before launch.
// R17 - Calibrate enable goes only to the currently chosen component.
// R18 - After sixth pass, clear control, close gate, idle both generators.
`timescale 1ns/10ps
`include "tcs_regs.svh"
module tcs_sequencer #(
   parameter int STEP_CYCLES = `TCS_STEP_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic inflight_start_relay_a,
   input wire logic inflight_start_relay_b,
   input wire logic preflight_mode_relay,
   input wire logic ground_sideband_select_relay,
   input wire logic [2:0] ground_level,
   output logic [6:0] cal_enable,
   output logic drivers_enabled,
   output logic [2:0] cal_level,
   output logic sideband_cal_relay,
   output logic sideband_ground_path,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ==================================================================
   // Pin synchronisers
   logic [6:0] sync1;
   logic [6:0] sync2;
   logic [2:0] level_q;
   tcs_pkg::tcs_level_t cmd_level;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1 <= 7'h00;
         sync2 <= 7'h00;
         {level_q, cmd_level} <= 6'h00;
      end
      else
      begin
         sync1 <= {ground_level, ground_sideband_select_relay, preflight_mode_relay,
                   inflight_start_relay_b, inflight_start_relay_a};
         sync2 <= sync1;
         // Level bits cross one by one, so a code is taken only after two equal samples.
         level_q <= sync2[6:4];
         if (sync2[6:4] == level_q)
            cmd_level <= level_q;
      end
   end
   logic start_in;
   logic pre_in;
   logic start_d;
   assign start_in = sync2[0] | sync2[1]; // [R7]
   assign pre_in = sync2[2]; // [R7]

   // ==================================================================
   // Control flip-flop and selector
   logic ctrl;
   tcs_pkg::tcs_sel_t sel;
   logic [2:0] passes;
   logic tick;
   logic pass_done;
   logic ctrl_set;
   logic finish;
   logic [6:0] ssb_map;
   assign ctrl_set = start_in & ~start_d & ~pre_in & ~ctrl; // [R1]
   assign finish = ctrl & pass_done & (passes == `TCS_PASSES - 3'h1); // [R14]

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         start_d <= 1'b0;
         ctrl <= 1'b0;
         sel <= 3'h0;
         passes <= 3'h0;
      end
      else
      begin
         start_d <= start_in;
         if (pre_in)
         begin
            ctrl <= 1'b0; // [R6]
            sel <= 3'h0;
            passes <= 3'h0;
         end
         else if (ctrl_set)
         begin
            ctrl <= 1'b1; // [R1]
            sel <= 3'h1; // [R2]
            passes <= 3'h0;
         end
         else if (finish)
         begin
            ctrl <= 1'b0; // [R18]
            sel <= 3'h0;
            passes <= 3'h0;
         end
         else if (ctrl && pass_done)
         begin
            sel <= sel + 3'h1; // [R4]
            passes <= passes + 3'h1;
         end
      end
   end

   // Decodes a selector step into a one-hot calibrate command.
   function automatic logic [6:0] step_onehot(input tcs_pkg::tcs_sel_t s);
      step_onehot = (s == 3'h0) ? 7'h00 : 7'(7'h01 << (s - 3'h1));
   endfunction

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cal_enable <= 7'h00;
         drivers_enabled <= 1'b0;
         sideband_cal_relay <= 1'b0;
         sideband_ground_path <= 1'b0;
      end
      else
      begin
         // Drivers stay enabled only while the start command is held.
         drivers_enabled <= start_in & ~pre_in; // [R1] [R5]
         cal_enable <= (start_in && !pre_in && ctrl) ? step_onehot(sel) : 7'h00; // [R3] [R17]
         sideband_cal_relay <= ctrl & |(step_onehot(sel) & ssb_map); // [R15]
         sideband_ground_path <= pre_in & sync2[3]; // [R16]
      end
   end

   // ==================================================================
   // Voltage stepper
   tcs_pkg::tcs_gate_t gate;
   tcs_pkg::tcs_gate_t next_gate;
   logic [31:0] tcnt;
   logic mismatch;
   // Inflight holds the comparator in no-compare; codes above full scale never match.
   assign mismatch = pre_in ? (cal_level != cmd_level) : 1'b1; // [R9] [R11] [R13]
   assign next_gate = (pre_in ? mismatch : ctrl & ~finish) ? tcs_pkg::TCS_GATE_OPEN
                                                          : tcs_pkg::TCS_GATE_CLOSED; // [R14]
   assign tick = (gate == tcs_pkg::TCS_GATE_OPEN) && (tcnt == 32'(STEP_CYCLES - 1)); // [R10]
   assign pass_done = tick && (cal_level == `TCS_LEVEL_TOP); // [R4] [R12]

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         gate <= tcs_pkg::TCS_GATE_CLOSED;
         tcnt <= 32'h0;
         cal_level <= 3'h0;
      end
      else
      begin
         gate <= next_gate;
         case (gate)
            tcs_pkg::TCS_GATE_CLOSED:
            begin
               tcnt <= 32'h0;
               if (next_gate == tcs_pkg::TCS_GATE_OPEN)
                  cal_level <= 3'h0; // [R9] [R2]
               else if (!pre_in)
                  cal_level <= 3'h0; // [R18]
            end
            tcs_pkg::TCS_GATE_OPEN:
            begin
               tcnt <= tick ? 32'h0 : tcnt + 32'h1;
               if (tick)
                  cal_level <= (cal_level == `TCS_LEVEL_TOP) ? 3'h0 : cal_level + 3'h1; // [R8]
            end
            default:
               tcnt <= 32'h0;
         endcase
      end
   end

   // ==================================================================
   // AXI4-Lite slave
   logic aw_held;
   logic w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   // Ready drops when an item is taken and returns once the response is accepted.
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TCS_RESP_OKAY;
         ssb_map <= `TCS_SSB_MAP_RST;
         {s_axi_awready, s_axi_wready} <= 2'h3;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (aw_held && w_held)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == `TCS_SSB_MAP_OFS)
            begin
               s_axi_bresp <= `TCS_RESP_OKAY;
               if (w_strb[0])
                  ssb_map <= w_data[6:0];
            end
            else
               s_axi_bresp <= `TCS_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            {s_axi_bvalid, s_axi_awready, s_axi_wready} <= 3'h3;
      end
   end

   logic [31:0] status;
   always_comb
   begin
      status = 32'h0;
      status[`TCS_ST_LEVEL_LSB +: 3] = cal_level;
      status[`TCS_ST_SEL_LSB +: 3] = sel;
      status[`TCS_ST_PASS_LSB +: 3] = passes;
      status[`TCS_ST_CTRL_BIT] = ctrl;
      status[`TCS_ST_RUN_BIT] = gate;
      status[`TCS_ST_PRE_BIT] = pre_in;
      status[`TCS_ST_INFL_BIT] = start_in;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `TCS_RESP_OKAY;
         s_axi_arready <= 1'b1;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0;
         s_axi_rresp <= `TCS_RESP_OKAY;
         if (s_axi_araddr == `TCS_STATUS_OFS)
            s_axi_rdata <= status;
         else if (s_axi_araddr == `TCS_SSB_MAP_OFS)
            s_axi_rdata <= {25'h0, ssb_map};
         else
         begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TCS_RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
         {s_axi_rvalid, s_axi_arready} <= 2'h1;
   end

   // ==================================================================
   // Assertions
   ctrl_start_a: assert property (@(posedge clk) disable iff (!nrst) // [R1] [R2]
      ctrl_set |=> ctrl && sel == 3'h1) else $error("start did not set control");
   step_one_a: assert property (@(posedge clk) disable iff (!nrst) // [R3]
      (ctrl && sel == 3'h1 && start_in && !pre_in) |=> cal_enable == 7'h01)
      else $error("step one command missing");
   sel_advance_a: assert property (@(posedge clk) disable iff (!nrst) // [R4]
      (ctrl && pass_done && !finish && !pre_in) |=> sel == $past(sel) + 3'h1)
      else $error("selector did not advance");
   pre_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // [R6]
      pre_in[*2] |-> cal_enable == 7'h00 && !ctrl) else $error("selector active in preflight");
   level_range_a: assert property (@(posedge clk) disable iff (!nrst) // [R8]
      cal_level <= `TCS_LEVEL_TOP) else $error("level out of range");
   pre_restart_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
      (pre_in && gate == tcs_pkg::TCS_GATE_CLOSED && mismatch && $stable(pre_in))
      |=> gate == tcs_pkg::TCS_GATE_OPEN && cal_level == 3'h0)
      else $error("preflight mismatch did not restart");
   tick_gap_a: assert property (@(posedge clk) disable iff (!nrst) // [R10]
      tick |=> !tick && tcnt == 32'h0) else $error("step pulses too close");
   inflight_run_a: assert property (@(posedge clk) disable iff (!nrst) // [R13] [R14]
      (ctrl && !pre_in && !finish) |=> gate == tcs_pkg::TCS_GATE_OPEN)
      else $error("inflight gate closed early");
   enable_onehot_a: assert property (@(posedge clk) disable iff (!nrst) // [R17]
      $onehot0(cal_enable)) else $error("more than one calibrate enable");
   run_finish_a: assert property (@(posedge clk) disable iff (!nrst) // [R18]
      finish |=> !ctrl && sel == 3'h0 && gate == tcs_pkg::TCS_GATE_CLOSED && cal_level == 3'h0)
      else $error("run did not end after six passes");
   ssb_relay_a: assert property (@(posedge clk) disable iff (!nrst) // [R15]
      (ctrl && |(step_onehot(sel) & ssb_map)) |=> sideband_cal_relay)
      else $error("sideband relay not closed");
endmodule // tcs_sequencer

// File: src/tcs_regs.svh
// Register offsets, reset values and timing counts of the calibration sequencer.
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH
// =====================================================================
// Register map
`define TCS_STATUS_OFS 4'h0
`define TCS_SSB_MAP_OFS 4'h4
`define TCS_SSB_MAP_RST 7'h07
// Status fields.
`define TCS_ST_LEVEL_LSB 0
`define TCS_ST_SEL_LSB 4
`define TCS_ST_PASS_LSB 8
`define TCS_ST_CTRL_BIT 12
`define TCS_ST_RUN_BIT 13
`define TCS_ST_PRE_BIT 14
`define TCS_ST_INFL_BIT 15
// =====================================================================
// Timing
`define TCS_CLK_HZ 20000000
`define TCS_STEP_MS 140
`define TCS_STEP_CYCLES ((`TCS_CLK_HZ / 1000) * `TCS_STEP_MS)
`define TCS_LEVEL_TOP 3'h4
`define TCS_SEL_STEPS 7
`define TCS_PASSES 3'h6
`define TCS_RESP_OKAY 2'h0
`define TCS_RESP_SLVERR 2'h2
`endif

// File: src/tcs_pkg.sv
// Types shared by the calibration sequencer.
package tcs_pkg;
   typedef enum logic [0:0] {TCS_GATE_CLOSED = 1'b0, TCS_GATE_OPEN = 1'b1} tcs_gate_t;
   typedef logic [2:0] tcs_level_t;
   typedef logic [2:0] tcs_sel_t;
endpackage

// File: dv/tcs_ground_model.sv
// Ground control model that holds either start relay for the commanded time.
`timescale 1ns/10ps
module tcs_ground_model #(
   parameter int HOLD = 130
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start_req,
   input wire logic start_sel,
   output logic relay_a,
   output logic relay_b
);
   int hold_cnt;
   logic sel_q;
   // ==========================================
   // Start command
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         hold_cnt <= 0;
         sel_q <= 1'b0;
      end
      else if (start_req)
      begin
         hold_cnt <= HOLD;
         sel_q <= start_sel;
      end
      else if (hold_cnt > 0)
         hold_cnt <= hold_cnt - 1;
   end
   assign relay_a = (hold_cnt > 0) && !sel_q;
   assign relay_b = (hold_cnt > 0) && sel_q;
endmodule // tcs_ground_model

// File: dv/telemetry_calibration_sequencer_test.sv
// Self-checking bench of the calibration sequencer.
`timescale 1ns/10ps
`include "tcs_regs.svh"
`define CHK(nm, e, g) \
   begin \
      tests_run++; \
      if ((g) !== (e)) \
      begin \
         err_count++; \
         $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
      end \
   end
module telemetry_calibration_sequencer_test;
   localparam int STEP = 4;
   localparam int RUN = 6 * 5 * STEP;
   logic clk = 0, nrst = 0, start_req = 0, start_sel = 0, pre = 0, gssb = 0;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic relay_a, relay_b, drv, ssb, gpath, bv, rv, awr, wr, arr;
   logic [2:0] glev = 0, lev;
   logic [6:0] en, map;
   logic [3:0] awa = 0, ara = 0, ws = 0;
   logic [31:0] wd = 0, rd, got;
   logic [1:0] bresp, rresp, resp;
   int err_count = 0, tests_run = 0;
   always #25 clk = ~clk;
   tcs_ground_model #(.HOLD(RUN + 20)) tcs_ground_model_inst (.clk(clk), .nrst(nrst),
      .start_req(start_req), .start_sel(start_sel), .relay_a(relay_a), .relay_b(relay_b));
   tcs_sequencer #(.STEP_CYCLES(STEP)) tcs_sequencer_inst (.clk(clk), .nrst(nrst),
      .inflight_start_relay_a(relay_a), .inflight_start_relay_b(relay_b),
      .preflight_mode_relay(pre), .ground_sideband_select_relay(gssb), .ground_level(glev),
      .cal_enable(en), .drivers_enabled(drv), .cal_level(lev), .sideband_cal_relay(ssb),
      .sideband_ground_path(gpath), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
      .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // ==========================================
   // Bus master: values read after an edge are those that edge sampled.
   task automatic axi(input logic wr_op, input logic [3:0] a, input logic [31:0] d);
      logic done;
      int n;
      done = 0;
      awa <= a;
      ara <= a;
      wd <= d;
      ws <= 4'hf;
      awv <= wr_op;
      wv <= wr_op;
      br <= wr_op;
      arv <= !wr_op;
      rr <= !wr_op;
      for (n = 0; n < 40 && !done; n++)
      begin
         @(posedge clk);
         if (awv && awr)
            awv <= 0;
         if (wv && wr)
            wv <= 0;
         if (arv && arr)
            arv <= 0;
         done = wr_op ? (bv && br) : (rv && rr);
         resp = wr_op ? bresp : rresp;
         got = rd;
      end
      br <= 0;
      rr <= 0;
      `CHK("bus answer", 1'b1, done)
      if (!done)
         test_done();
      tick(1);
   endtask
   // ==========================================
   // Inflight run against an integer model of level and pass count.
   task automatic flight(input logic sel);
      int n, passes, since;
      logic [2:0] prev;
      passes = 0;
      since = -1000;
      prev = 0;
      glev <= 3'($urandom % 5);
      start_sel <= sel;
      start_req <= 1;
      tick(1);
      start_req <= 0;
      for (n = 0; n < 20 && en === 7'h00; n++)
         tick(1);
      `CHK("first enable", 7'h01, en)
      if (en === 7'h00)
         test_done();
      `CHK("drivers", 1'b1, drv)
      for (n = 0; n < RUN + 40 && passes < 6; n++)
      begin
         tick(1);
         since++;
         if (lev !== prev)
         begin
            if (since > 0)
               `CHK("step spacing", STEP, since)
            `CHK("level order", 3'((prev + 1) % 5), lev)
            passes += (prev == 3'h4);
            prev = lev;
            since = 0;
            if (lev == 3'h2)
            begin
               `CHK("enable", 7'(1 << passes), en)
               `CHK("sideband", (|(7'(1 << passes) & map)), ssb)
            end
         end
      end
      `CHK("passes", 6, passes)
      if (passes != 6)
         test_done();
      tick(3 * STEP);
      `CHK("run end", 10'h000, ({en, lev}))
      for (n = 0; n < RUN + 30 && (relay_a || relay_b); n++)
         tick(1);
      tick(5);
      `CHK("drivers off", 1'b0, drv)
      $display("flight test done");
   endtask
   // ==========================================
   // Preflight level command.
   task automatic preflight(input logic [2:0] l);
      int n, moves;
      logic [2:0] prev;
      moves = 0;
      glev <= l;
      pre <= 1;
      for (n = 0; n < 6 * STEP + 8; n++)
      begin
         tick(1);
         `CHK("idle selector", 7'h00, en)
      end
      prev = lev;
      for (n = 0; n < 10 * STEP; n++)
      begin
         tick(1);
         moves += (lev !== prev);
         prev = lev;
      end
      if (l < 3'h5)
         `CHK("held level", l, lev)
      else
         `CHK("cycling", 1'b1, moves >= 9)
      $display("preflight test done");
   endtask
   initial
   begin
      void'($urandom(32'h7f7e));
      map = `TCS_SSB_MAP_RST;
      tick(2);
      nrst <= 1;
      tick(1);
      axi(0, `TCS_SSB_MAP_OFS, 0);
      `CHK("map reset", 32'(`TCS_SSB_MAP_RST), got)
      axi(0, `TCS_STATUS_OFS, 0);
      `CHK("status reset", 32'h0, got)
      axi(1, `TCS_STATUS_OFS, $urandom);
      `CHK("status write", `TCS_RESP_SLVERR, resp)
      axi(1, 4'h8, $urandom);
      `CHK("unmapped write", `TCS_RESP_SLVERR, resp)
      axi(0, 4'h8, 0);
      `CHK("unmapped read", ({`TCS_RESP_SLVERR, 32'h0}), ({resp, got}))
      $display("register test done");
      flight(0);
      map = 7'($urandom);
      axi(1, `TCS_SSB_MAP_OFS, {25'h0, map});
      `CHK("map write", `TCS_RESP_OKAY, resp)
      axi(0, `TCS_SSB_MAP_OFS, 0);
      `CHK("map read", ({25'h0, map}), got)
      flight(1);
      pre <= 1;
      start_req <= 1;
      tick(1);
      start_req <= 0;
      foreach (map[i])
         preflight(i == 6 ? 3'($urandom) : 3'(i % 5));
      gssb <= 1;
      tick(5);
      `CHK("ground path", 1'b1, gpath)
      pre <= 0;
      tick(5);
      `CHK("ground path off", 1'b0, gpath)
      test_done();
   end
endmodule // telemetry_calibration_sequencer_test
